// ### rtl/rcr_pkg.sv
package rcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_SOF   = 8'h34;
  localparam logic [7:0] IDX_CTRL  = 8'h35;
  localparam logic [7:0] IDX_WAIT  = 8'h36;
  localparam logic [7:0] IDX_THR   = 8'h37;
  localparam logic [7:0] IDX_SETUP = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_SOF   = {IDX_SOF, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_WAIT  = {IDX_WAIT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_THR   = {IDX_THR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SETUP = {IDX_SETUP, 2'b00};
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and write masks
  // ----------------------------------------------------------------
  localparam int unsigned SOF_EN_BIT   = 5;
  localparam int unsigned SOF_SEEN_BIT = 4;
  localparam int unsigned CAR_EN_BIT   = 2;
  localparam int unsigned CAR_SEEN_BIT = 1;
  localparam int unsigned CAR_LIVE_BIT = 0;
  localparam logic [7:0] SOF_W_MASK   = 8'h24;
  localparam logic [7:0] CTRL_W_MASK  = 8'hCF;
  localparam logic [7:0] SETUP_W_MASK = 8'hF3;
  localparam int unsigned ALLOW_BIT    = 7;
  localparam int unsigned MULTI_BIT    = 6;
  localparam int unsigned SUP_BIT      = 3;
  localparam int unsigned BAUD_MSB     = 2;
  localparam int unsigned UNIT_BIT     = 7;
  localparam int unsigned CNT_MSB      = 6;
  localparam int unsigned DEC_MSB      = 7;
  localparam int unsigned DEC_LSB      = 4;
  localparam int unsigned PH_MSB       = 3;
  localparam int unsigned SINGLE_BIT   = 7;
  localparam int unsigned CONV_BIT     = 6;
  localparam int unsigned SEL_MSB      = 5;
  localparam int unsigned SEL_LSB      = 4;
  localparam int unsigned COLL_MSB     = 1;

  // ----------------------------------------------------------------
  // Encodings and counts
  // ----------------------------------------------------------------
  localparam logic [2:0] BAUD_26K = 3'h2;
  localparam logic [2:0] BAUD_52K = 3'h3;
  localparam logic [1:0] COLL_OFF = 2'h3;
  localparam logic [1:0] SUP_BYTES = 2'h3;
  localparam logic [3:0] CARR_DIV_LAST = 4'hF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       sof;
    logic       carrier_now;
    logic       byte_valid;
    logic       byte_partial;
    logic [7:0] byte_data;
    logic       frame_end;
    logic       error;
    logic       collision;
  } rcr_rx_evt_s;

  typedef struct packed {
    logic [2:0] baud_code;
    logic       baud_valid;
    logic       rate_52k;
    logic [3:0] decoder_min_level;
    logic [3:0] phase_detector_min_level;
    logic [1:0] collision_threshold;
    logic       collision_enable;
    logic [1:0] signal_input_select;
    logic       converter_mode;
    logic       single_input;
  } rcr_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_IGNORE = 3'b001,
    ST_LISTEN = 3'b010,
    ST_FRAME  = 3'b011,
    ST_APPEND = 3'b100
  } rcr_state_e;

endpackage

// ### rtl/rcr_receiver_config_regs.sv
// Behaviour
// R01: Frame-start enable plus detected start raises the frame-start interrupt.
// R02: Start-of-frame sets a sticky flag, held until software clears it.
// R03: Subcarrier enable plus detected subcarrier raises the same interrupt.
// R04: Subcarrier detection sets a sticky flag, held until software clears it.
// R05: A read-only bit shows the subcarrier detection live, unlatched.
// R06: Partial-byte option lets incomplete bytes reach the FIFO despite checksum.
// R07: Multi-frame option keeps the receiver running after each frame.
// R08: Multi-frame mode appends a copy of the error status after each frame.
// R09: Suppression: error or collision in first three bytes resets the FIFO.
// R10: Suppression: a frame shorter than three bytes flags a disturbance error.
// R11: Disturbance cases never raise the receive-complete interrupt.
// R12: Host should not read FIFO before three bytes with forced checksum write.
// R13: Baud field code 2h selects 26 kBd, 3h 52 kBd, others reserved.
// R14: Wait unit is 16 carrier periods, or half a bit period when set.
// R15: After transmission all receiver input is ignored for the wait time; the live subcarrier read bit still follows rx_evt.carrier_now.
// R16: Upper threshold nibble is the bit decoder minimum level.
// R17: Lower threshold nibble is the phase detector minimum level.
// R18: Collision level 0h 1/8, 1h 1/4, 2h 1/2, 3h detection off.
// R19: Input select picks idle, analog, envelope or generic digital input.
// R20: Converter mode bit selects normal reception or low-power detection.
// R21: Reserved bits read zero; status bits ignore writes except clears.
`timescale 1ns/10ps
module rcr_receiver_config_regs
  import rcr_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Receiver front end
  input  wire rcr_rx_evt_s       rx_evt,
  input  wire logic              tx_end,
  input  wire logic              carrier_tick,
  input  wire logic              half_bit_tick,
  input  wire logic              crc_enable,
  input  wire logic [7:0]        error_status,
  // FIFO side
  output      logic              fifo_wr_valid,
  output      logic [7:0]        fifo_wr_data,
  output      logic              fifo_reset,
  // Status and interrupts
  output      logic              frame_start_irq,
  output      logic              rx_done_irq,
  output      logic              disturbance_error,
  output      logic              input_ignored,
  output      rcr_cfg_s          cfg
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]        sof_r, ctrl_r, wait_r, thr_r, setup_r;
  logic              aw_held_r, w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wdata_r;
  logic              wlane_r;
  rcr_state_e        state_r;
  logic [6:0]        wait_cnt_r;
  logic [3:0]        carr_div_r;
  logic [1:0]        byte_cnt_r;
  logic              wr_fire, rd_fire, sof_hit, car_hit, unit_tick;
  logic [7:0]        rd_val;
  logic              rd_ok;
  logic              wr_ok;
  logic              short_frame, early_fault, drop_partial;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held_r && w_held_r;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_ok         = (awaddr_r == ADDR_SOF) || (awaddr_r == ADDR_CTRL) ||
                         (awaddr_r == ADDR_WAIT) || (awaddr_r == ADDR_THR) ||
                         (awaddr_r == ADDR_SETUP);

  // Capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= REG_RESET;
      wlane_r   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata[7:0];
        wlane_r  <= s_axi_wstrb[0];
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode; reserved bits come back as zero
  always_comb
  begin
    rd_val = 8'h00;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      ADDR_SOF:
      begin
        rd_val = sof_r & (SOF_W_MASK | 8'h12);
        // R05: live subcarrier
        rd_val[CAR_LIVE_BIT] = rx_evt.carrier_now;
      end
      ADDR_CTRL:  rd_val = ctrl_r;
      ADDR_WAIT:  rd_val = wait_r;
      ADDR_THR:   rd_val = thr_r;
      ADDR_SETUP: rd_val = setup_r;
      default:    rd_ok  = 1'b0;
    endcase
  end

  // Read data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_val};
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // R21: masked writes, reserved stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r  <= REG_RESET;
      wait_r  <= REG_RESET;
      thr_r   <= REG_RESET;
      setup_r <= REG_RESET;
    end
    else if (wr_fire && wlane_r)
    begin
      if (awaddr_r == ADDR_CTRL)
        ctrl_r <= wdata_r & CTRL_W_MASK;
      if (awaddr_r == ADDR_WAIT)
        wait_r <= wdata_r;
      if (awaddr_r == ADDR_THR)
        thr_r <= wdata_r;
      if (awaddr_r == ADDR_SETUP)
        setup_r <= wdata_r & SETUP_W_MASK;
    end
  end

  // Detection flags and enables; a new event beats a clear
  assign sof_hit = rx_evt.sof && !input_ignored;
  assign car_hit = rx_evt.carrier_now && !input_ignored;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sof_r <= REG_RESET;
    else
    begin
      if (wr_fire && wlane_r && awaddr_r == ADDR_SOF)
      begin
        sof_r[SOF_EN_BIT] <= wdata_r[SOF_EN_BIT];
        sof_r[CAR_EN_BIT] <= wdata_r[CAR_EN_BIT];
        if (wdata_r[SOF_SEEN_BIT])
          sof_r[SOF_SEEN_BIT] <= 1'b0;
        if (wdata_r[CAR_SEEN_BIT])
          sof_r[CAR_SEEN_BIT] <= 1'b0;
      end
      // R02: sticky start flag
      if (sof_hit)
        sof_r[SOF_SEEN_BIT] <= 1'b1;
      // R04: sticky subcarrier flag
      if (car_hit)
        sof_r[CAR_SEEN_BIT] <= 1'b1;
    end
  end

  // R01: start interrupt path
  // R03: subcarrier interrupt path
  assign frame_start_irq = (sof_r[SOF_EN_BIT] && sof_r[SOF_SEEN_BIT]) ||
                           (sof_r[CAR_EN_BIT] && sof_r[CAR_SEEN_BIT]);

  // Decoded settings to the analog and decoder blocks
  always_comb
  begin
    cfg.baud_code  = ctrl_r[BAUD_MSB:0];
    // R13: baud selection
    cfg.baud_valid = (ctrl_r[BAUD_MSB:0] == BAUD_26K) ||
                     (ctrl_r[BAUD_MSB:0] == BAUD_52K);
    cfg.rate_52k   = (ctrl_r[BAUD_MSB:0] == BAUD_52K);
    // R16: decoder threshold
    cfg.decoder_min_level = thr_r[DEC_MSB:DEC_LSB];
    // R17: phase detector threshold
    cfg.phase_detector_min_level = thr_r[PH_MSB:0];
    // R18: collision level and off code
    cfg.collision_threshold = setup_r[COLL_MSB:0];
    cfg.collision_enable    = (setup_r[COLL_MSB:0] != COLL_OFF);
    // R19: input select
    cfg.signal_input_select = setup_r[SEL_MSB:SEL_LSB];
    // R20: converter mode
    cfg.converter_mode = setup_r[CONV_BIT];
    cfg.single_input   = setup_r[SINGLE_BIT];
  end

  // ----------------------------------------------------------------
  // Post-transmit ignore timer
  // ----------------------------------------------------------------
  // R14: unit is 16 carrier ticks or one half-bit tick
  assign unit_tick = wait_r[UNIT_BIT] ? half_bit_tick :
                     (carrier_tick && carr_div_r == CARR_DIV_LAST);
  assign input_ignored = (state_r == ST_IGNORE);

  // Carrier tick divider, restarted at each transmission end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tx_end)
      carr_div_r <= 4'h0;
    else if (carrier_tick)
      carr_div_r <= carr_div_r + 4'h1;
  end

  // ----------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------
  assign early_fault  = ctrl_r[SUP_BIT] && byte_cnt_r < SUP_BYTES &&
                        (rx_evt.error || rx_evt.collision);
  assign short_frame  = ctrl_r[SUP_BIT] && byte_cnt_r < SUP_BYTES &&
                        rx_evt.frame_end;
  assign drop_partial = rx_evt.byte_partial && crc_enable &&
                        !ctrl_r[ALLOW_BIT];

  // Sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r    <= ST_IDLE;
      wait_cnt_r <= 7'h00;
      byte_cnt_r <= 2'h0;
    end
    else if (tx_end)
    begin
      // R15: ignore input for the wait time
      wait_cnt_r <= wait_r[CNT_MSB:0];
      state_r    <= (wait_r[CNT_MSB:0] == 7'h00) ? ST_LISTEN : ST_IGNORE;
    end
    else
    begin
      case (state_r)
        ST_IGNORE:
        begin
          if (unit_tick)
          begin
            wait_cnt_r <= wait_cnt_r - 7'h01;
            if (wait_cnt_r == 7'h01)
              state_r <= ST_LISTEN;
          end
        end
        ST_LISTEN:
        begin
          byte_cnt_r <= 2'h0;
          if (rx_evt.sof)
            state_r <= ST_FRAME;
        end
        ST_FRAME:
        begin
          if (rx_evt.byte_valid && byte_cnt_r != SUP_BYTES)
            byte_cnt_r <= byte_cnt_r + 2'h1;
          // R09: discard early bytes, wait for next start
          if (early_fault || short_frame)
            state_r <= ST_LISTEN;
          else if (rx_evt.frame_end)
          begin
            // R07: stay receiving in multi-frame mode
            if (ctrl_r[MULTI_BIT])
              state_r <= ST_APPEND;
            else
              state_r <= ST_IDLE;
          end
        end
        ST_APPEND: state_r <= ST_LISTEN;
        default:   state_r <= ST_IDLE;
      endcase
    end
  end

  // FIFO writes, resets and completion
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fifo_wr_valid     <= 1'b0;
      fifo_wr_data      <= 8'h00;
      fifo_reset        <= 1'b0;
      rx_done_irq       <= 1'b0;
      disturbance_error <= 1'b0;
    end
    else
    begin
      fifo_wr_valid     <= 1'b0;
      fifo_reset        <= 1'b0;
      rx_done_irq       <= 1'b0;
      disturbance_error <= 1'b0;
      if (state_r == ST_FRAME && !tx_end)
      begin
        // R06: partial byte passes only when allowed or checksum is off
        if (rx_evt.byte_valid && !drop_partial && !early_fault)
        begin
          fifo_wr_valid <= 1'b1;
          fifo_wr_data  <= rx_evt.byte_data;
        end
        // R09: early error or collision resets FIFO
        fifo_reset <= early_fault;
        // R10: short frame flags disturbance
        disturbance_error <= short_frame && !early_fault;
        // R11: no completion on disturbance
        rx_done_irq <= rx_evt.frame_end && !early_fault && !short_frame;
      end
      else if (state_r == ST_APPEND)
      begin
        // R08: append error status copy
        fifo_wr_valid <= 1'b1;
        fifo_wr_data  <= error_status;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sof_sticky_a: assert property (sof_hit |=> sof_r[SOF_SEEN_BIT]) // R02
    else $error("start flag not set");
  sof_irq_a: assert property (sof_hit && sof_r[SOF_EN_BIT] && !wr_fire
    |=> frame_start_irq) // R01
    else $error("start interrupt missing");
  car_irq_a: assert property (car_hit && sof_r[CAR_EN_BIT] && !wr_fire
    |=> frame_start_irq && sof_r[CAR_SEEN_BIT]) // R03
    else $error("subcarrier interrupt missing");
  car_hold_a: assert property (sof_r[CAR_SEEN_BIT] && !wr_fire
    |=> sof_r[CAR_SEEN_BIT]) // R04
    else $error("subcarrier flag lost");
  live_read_a: assert property (rd_fire && s_axi_araddr == ADDR_SOF
    |=> s_axi_rdata[CAR_LIVE_BIT] == $past(rx_evt.carrier_now)) // R05
    else $error("live bit wrong");
  partial_drop_a: assert property (state_r == ST_FRAME && !tx_end &&
    rx_evt.byte_valid && drop_partial |=> !fifo_wr_valid) // R06
    else $error("partial byte written");
  append_err_a: assert property (state_r == ST_FRAME && !tx_end &&
    rx_evt.frame_end && ctrl_r[MULTI_BIT] && !early_fault && !short_frame
    |=> ##1 fifo_wr_valid && fifo_wr_data == $past(error_status)) // R08
    else $error("error byte not appended");
  emd_reset_a: assert property (state_r == ST_FRAME && !tx_end &&
    early_fault |=> fifo_reset && !rx_done_irq && state_r == ST_LISTEN)
    // R09
    else $error("fifo not reset");
  short_flag_a: assert property (state_r == ST_FRAME && !tx_end &&
    short_frame && !early_fault |=> disturbance_error && !rx_done_irq)
    // R10
    else $error("short frame not flagged");
  no_done_a: assert property (disturbance_error || fifo_reset
    |-> !rx_done_irq) // R11
    else $error("completion on disturbance");
  ignore_hold_a: assert property (tx_end && wait_r[CNT_MSB:0] != 7'h00
    |=> input_ignored && wait_cnt_r == $past(wait_r[CNT_MSB:0])) // R15
    else $error("input not ignored");
  baud_sel_a: assert property (cfg.rate_52k |-> cfg.baud_valid &&
    ctrl_r[BAUD_MSB:0] == BAUD_52K) // R13
    else $error("baud decode wrong");

  multi_cov_c: cover property (state_r == ST_APPEND ##1 fifo_wr_valid);
  emd_cov_c: cover property (fifo_reset);
  done_cov_c: cover property (rx_done_irq);
  ignore_cov_c: cover property (input_ignored ##1 !input_ignored);

endmodule

// ### test/rcr_receiver_config_regs_tb.sv
`timescale 1ns/10ps
module rcr_receiver_config_regs_tb;
  import rcr_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              aclk, aresetn, car, coll;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  rcr_rx_evt_s       rx_evt;
  logic              tx_end, carrier_tick, half_bit_tick, crc_enable;
  logic [7:0]        error_status, fifo_wr_data, lfsr, thr_v;
  logic              fifo_wr_valid, fifo_reset, frame_start_irq;
  logic              rx_done_irq, disturbance_error, input_ignored;
  rcr_cfg_s          cfg;
  int                failures, n_tests;
  logic [ADDR_W-1:0] ad [5];

  rcr_receiver_config_regs rcr_receiver_config_regs_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_evt, .tx_end, .carrier_tick,
    .half_bit_tick, .crc_enable, .error_status, .fifo_wr_valid,
    .fifo_wr_data, .fifo_reset, .frame_start_irq, .rx_done_irq,
    .disturbance_error, .input_ignored, .cfg
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Clock, 10 ns period
  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // Next random byte
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Writable bits per address
  function automatic logic [7:0] rmask(input logic [ADDR_W-1:0] a);
    return a == ADDR_SOF ? SOF_W_MASK : a == ADDR_CTRL ? CTRL_W_MASK :
           a == ADDR_SETUP ? SETUP_W_MASK : 8'hFF;
  endfunction

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 40)
    begin
      failures++;
      close_out;
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'h0;
    hang(n);
    chk(s_axi_bresp, r);
  endtask

  // Bus read, full word kept in rd_v
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'h0;
    rd_v = s_axi_rdata;
    hang(n);
    chk(s_axi_rresp, r);
  endtask

  // One-cycle receiver event, returns once its result has landed
  task automatic ev(input logic s, b, p, f, er, input logic [7:0] dt);
    rcr_rx_evt_s e;
    e = '0;
    e.carrier_now = car;
    @(posedge aclk);
    rx_evt <= '{s, car, b, p, dt, f, er, coll};
    @(posedge aclk);
    rx_evt <= e;
    #1;
  endtask

  // One-cycle pulse on the transmit-end or half-bit input
  task automatic pulse(input bit hb);
    @(posedge aclk);
    if (hb)
      half_bit_tick <= 1'h1;
    else
      tx_end <= 1'h1;
    @(posedge aclk);
    half_bit_tick <= 1'h0;
    tx_end        <= 1'h0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, car, coll} = '0;
    {s_axi_arvalid, s_axi_rready, tx_end, half_bit_tick} = '0;
    {carrier_tick, crc_enable, rx_evt, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'hF;
    error_status = 8'h0;
    lfsr         = 8'h3A;
    ad = '{ADDR_SOF, ADDR_CTRL, ADDR_WAIT, ADDR_THR, ADDR_SETUP};
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    foreach (ad[i])
    begin
      rd(ad[i], RESP_OKAY);
      chk(rd_v, 32'h0);
    end
    repeat (3) foreach (ad[i])
    begin
      lfsr = nxt(lfsr);
      wr(ad[i], lfsr, RESP_OKAY);
      if (ad[i] == ADDR_THR)
        thr_v = lfsr;
      rd(ad[i], RESP_OKAY);
      chk(rd_v, {24'h0, lfsr & rmask(ad[i])});
    end
    chk(cfg.decoder_min_level, thr_v[7:4]);
    chk(cfg.phase_detector_min_level, thr_v[3:0]);
    wr(10'h3FC, 8'hFF, RESP_SLVERR);
    rd(10'h3FC, RESP_SLVERR);
    chk(rd_v, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_CTRL, 8'(c), RESP_OKAY);
      wr(ADDR_SETUP, 8'(c * 16 + c + (c % 2) * 128), RESP_OKAY);
      chk(cfg.baud_code, c);
      chk(cfg.baud_valid, c == 2 || c == 3);
      chk(cfg.rate_52k, c == 3);
      chk(cfg.collision_enable, c % 4 != 3);
      chk(cfg.collision_threshold, c % 4);
      chk(cfg.single_input, c % 2);
      chk(cfg.signal_input_select, c % 4);
      chk(cfg.converter_mode, c / 4);
    end
    $display("test fields done");
    wr(ADDR_SOF, 8'h36, RESP_OKAY);
    car = 1'h1;
    ev(0, 0, 0, 0, 0, 8'h0);
    rd(ADDR_SOF, RESP_OKAY);
    chk(rd_v, 32'h27);
    chk(frame_start_irq, 1'h1);
    car = 1'h0;
    ev(0, 0, 0, 0, 0, 8'h0);
    wr(ADDR_SOF, 8'h26, RESP_OKAY);
    rd(ADDR_SOF, RESP_OKAY);
    chk(rd_v, 32'h24);
    chk(frame_start_irq, 1'h0);
    ev(1, 0, 0, 0, 0, 8'h0);
    rd(ADDR_SOF, RESP_OKAY);
    chk(rd_v, 32'h34);
    chk(frame_start_irq, 1'h1);
    wr(ADDR_SOF, 8'h04, RESP_OKAY);
    rd(ADDR_SOF, RESP_OKAY);
    chk(rd_v, 32'h14);
    chk(frame_start_irq, 1'h0);
    $display("test flags done");
    wr(ADDR_WAIT, 8'h00, RESP_OKAY);
    wr(ADDR_CTRL, 8'h40, RESP_OKAY);
    lfsr = nxt(lfsr);
    error_status <= lfsr;
    pulse(0);
    repeat (2)
    begin
      ev(1, 0, 0, 0, 0, 8'h0);
      lfsr = nxt(lfsr);
      ev(0, 1, 0, 0, 0, lfsr);
      chk(fifo_wr_valid, 1'h1);
      chk(fifo_wr_data, lfsr);
      ev(0, 0, 0, 1, 0, 8'h0);
      chk(rx_done_irq, 1'h1);
      @(posedge aclk);
      #1;
      chk(fifo_wr_valid, 1'h1);
      chk(fifo_wr_data, error_status);
    end
    $display("test multi done");
    wr(ADDR_CTRL, 8'h48, RESP_OKAY);
    ev(1, 0, 0, 0, 0, 8'h0);
    ev(0, 1, 0, 0, 0, 8'h5A);
    ev(0, 0, 0, 1, 0, 8'h0);
    chk(disturbance_error, 1'h1);
    chk(rx_done_irq, 1'h0);
    ev(1, 0, 0, 0, 0, 8'h0);
    ev(0, 1, 0, 0, 1, 8'hA5);
    chk(fifo_reset, 1'h1);
    chk(fifo_wr_valid, 1'h0);
    // Collision in an early byte, same as an error
    coll = 1'h1;
    ev(1, 0, 0, 0, 0, 8'h0);
    ev(0, 1, 0, 0, 0, 8'hC3);
    coll = 1'h0;
    chk(fifo_reset, 1'h1);
    chk(fifo_wr_valid, 1'h0);
    // bench never reads the FIFO early
    $display("test suppression done");
    crc_enable <= 1'h1;
    wr(ADDR_CTRL, 8'h40, RESP_OKAY);
    ev(1, 0, 0, 0, 0, 8'h0);
    ev(0, 1, 1, 0, 0, 8'h0F);
    chk(fifo_wr_valid, 1'h0);
    wr(ADDR_CTRL, 8'hC0, RESP_OKAY);
    ev(0, 1, 1, 0, 0, 8'h0F);
    chk(fifo_wr_valid, 1'h1);
    $display("test partial done");
    wr(ADDR_WAIT, 8'h83, RESP_OKAY);
    pulse(0);
    chk(input_ignored, 1'h1);
    repeat (2) pulse(1);
    chk(input_ignored, 1'h1);
    pulse(1);
    @(posedge aclk);
    #1;
    chk(input_ignored, 1'h0);
    // One unit of 16 carrier ticks
    wr(ADDR_WAIT, 8'h01, RESP_OKAY);
    pulse(0);
    carrier_tick <= 1'h1;
    repeat (15) @(posedge aclk);
    #1;
    chk(input_ignored, 1'h1);
    @(posedge aclk);
    carrier_tick <= 1'h0;
    #1;
    chk(input_ignored, 1'h0);
    $display("test ignore done");
    close_out;
  end

  // Watchdog for the whole run
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    close_out;
  end
endmodule
